// ===== core/tosw_pkg.sv
// shared constants for the one-shot / wait one-shot timer
package tosw_pkg;
    localparam int TOSW_W = 8;
    localparam logic [7:0] TOSW_ZERO = 8'h00;
    localparam logic [7:0] TOSW_RESET_LATCH = 8'hff;
    localparam logic [1:0] TOSW_HALF_HIGH = 2'h1;
    localparam logic [1:0] TOSW_HALF_DONE = 2'h2;
    typedef enum logic [2:0]
    {
        TOSW_IDLE = 3'h1,
        TOSW_WAIT = 3'h2,
        TOSW_PULSE = 3'h4
    } tosw_state_e;
endpackage : tosw_pkg

// ===== core/tosw_timer.sv
// one-shot and wait one-shot pulse timer with prescaler
`timescale 1ns/1ps
`default_nettype none
module tosw_timer
    import tosw_pkg::*;
#(
    parameter int W = TOSW_W
)
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_count_source,
    input wire logic i_wait_mode,
    input wire logic i_count_stop,
    input wire logic i_level_latch,
    input wire logic i_pin_trig_en,
    input wire logic i_trig_rising,
    input wire logic i_trig_pin,
    input wire logic i_start_wr,
    input wire logic i_start_wdata,
    input wire logic i_primary_wr,
    input wire logic [W-1:0] i_primary_data,
    input wire logic i_secondary_wr,
    input wire logic [W-1:0] i_secondary_data,
    input wire logic i_prescaler_wr,
    input wire logic [W-1:0] i_prescaler_data,
    input wire logic i_ext_wr,
    input wire logic i_primary_half_cycle_extend,
    input wire logic i_secondary_half_cycle_extend,
    output logic o_pulse_output_pin,
    output logic o_start_bit,
    output logic o_underflow_irq,
    output logic [W-1:0] o_timer_count,
    output logic [W-1:0] o_prescaler_count,
    output logic o_busy
);
    typedef struct packed
    {
        logic src_s1;
        logic src_s2;
        logic src_d;
        logic pin_s1;
        logic pin_s2;
        logic pin_d;
        logic [W-1:0] pri_latch;
        logic [W-1:0] sec_latch;
        logic [W-1:0] pre_latch;
        logic ext_p_stage;
        logic ext_s_stage;
        logic [W-1:0] sec_stage;
        logic ext_p;
        logic ext_s;
        logic [W-1:0] pri_act;
        logic [W-1:0] sec_act;
        logic [W-1:0] tmr;
        logic [W-1:0] pre;
        logic [1:0] half;
        logic start;
        logic out_active;
        logic irq;
        tosw_state_e st;
    } tosw_state_s;

    tosw_state_s cur;
    tosw_state_s nxt;

    logic src_tick;
    logic pin_edge;
    logic trig;
    logic pre_tick;
    logic ext_now;
    logic tmr_uf;
    logic abort_now;

    // one step of a down count, sized to the counter width
    localparam logic [W-1:0] CNT_STEP = {{(W-1){1'b0}}, 1'b1};

    // only the synchroniser's second stage feeds edge logic
    assign src_tick = cur.src_s2 & ~cur.src_d;
    assign pin_edge = i_trig_rising ? (cur.pin_s2 & ~cur.pin_d)
                                    : (~cur.pin_s2 & cur.pin_d);
    assign pre_tick = src_tick && (cur.pre == TOSW_ZERO);
    assign ext_now = (cur.st == TOSW_WAIT || !i_wait_mode) ? cur.ext_p
                                                           : cur.ext_s;
    // underflow waits one extra prescaled count period when extended
    assign tmr_uf = pre_tick && (cur.tmr == TOSW_ZERO) &&
                    (!ext_now || cur.half == TOSW_HALF_HIGH);

    always_comb
    begin
        nxt = cur;
        nxt.irq = 1'b0;
        nxt.src_s1 = i_count_source;
        nxt.src_s2 = cur.src_s1;
        nxt.src_d = cur.src_s2;
        nxt.pin_s1 = i_trig_pin;
        nxt.pin_s2 = cur.pin_s1;
        nxt.pin_d = cur.pin_s2;
        trig = 1'b0;
        if (i_secondary_wr)
        begin
            nxt.sec_stage = i_secondary_data;
        end
        if (i_ext_wr)
        begin
            nxt.ext_p_stage = i_primary_half_cycle_extend;
            nxt.ext_s_stage = i_secondary_half_cycle_extend;
        end
        if (i_prescaler_wr)
        begin
            nxt.pre_latch = i_prescaler_data;
        end
        // staged values move as one set on a primary write
        if (i_primary_wr)
        begin
            nxt.pri_latch = i_primary_data;
            nxt.sec_latch = i_secondary_wr ? i_secondary_data
                                           : cur.sec_stage;
            nxt.ext_p = i_ext_wr ? i_primary_half_cycle_extend
                                 : cur.ext_p_stage;
            nxt.ext_s = i_ext_wr ? i_secondary_half_cycle_extend
                                 : cur.ext_s_stage;
        end
        if (cur.st != TOSW_IDLE && src_tick)
        begin
            nxt.pre = (cur.pre == TOSW_ZERO) ? cur.pre_latch
                                              : cur.pre - CNT_STEP;
        end
        if (pre_tick && cur.st != TOSW_IDLE)
        begin
            if (cur.tmr != TOSW_ZERO)
            begin
                nxt.tmr = cur.tmr - CNT_STEP;
            end
            else if (ext_now && cur.half != TOSW_HALF_HIGH)
            begin
                nxt.half = TOSW_HALF_HIGH;
            end
        end
        case (cur.st)
            TOSW_IDLE:
            begin
                // triggers are decoded only while idle, so no restart
                trig = !i_count_stop &&
                       ((i_start_wr && i_start_wdata) ||
                        (i_pin_trig_en && pin_edge));
                if (trig)
                begin
                    nxt.start = 1'b1;
                    nxt.pre = cur.pre_latch;
                    nxt.tmr = cur.pri_latch;
                    nxt.pri_act = cur.pri_latch;
                    nxt.sec_act = cur.sec_latch;
                    nxt.half = TOSW_HALF_DONE;
                    nxt.out_active = !i_wait_mode;
                    nxt.st = i_wait_mode ? TOSW_WAIT : TOSW_PULSE;
                end
                else if (i_start_wr)
                begin
                    nxt.start = i_start_wdata;
                end
            end
            TOSW_WAIT:
            begin
                if (tmr_uf)
                begin
                    nxt.irq = 1'b1;
                    nxt.tmr = cur.sec_act;
                    nxt.half = TOSW_HALF_DONE;
                    nxt.out_active = 1'b1;
                    nxt.st = TOSW_PULSE;
                end
            end
            TOSW_PULSE:
            begin
                if (tmr_uf)
                begin
                    nxt.irq = 1'b1;
                    nxt.out_active = 1'b0;
                    nxt.start = 1'b0;
                    nxt.st = TOSW_IDLE;
                end
            end
            default:
            begin
                nxt.st = TOSW_IDLE;
                nxt.out_active = 1'b0;
            end
        endcase
        // a zero write aborts a running wait or pulse
        if (cur.st != TOSW_IDLE && i_start_wr && !i_start_wdata)
        begin
            nxt.out_active = 1'b0;
            nxt.start = 1'b0;
            nxt.st = TOSW_IDLE;
        end
        if (cur.st != TOSW_IDLE && i_count_stop)
        begin
            nxt.out_active = 1'b0;
            nxt.start = 1'b0;
            nxt.st = TOSW_IDLE;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            cur <= '0;
            cur.pri_latch <= TOSW_RESET_LATCH;
            cur.sec_latch <= TOSW_RESET_LATCH;
            cur.sec_stage <= TOSW_RESET_LATCH;
            cur.tmr <= TOSW_RESET_LATCH;
            cur.st <= TOSW_IDLE;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign o_pulse_output_pin = cur.out_active ^ i_level_latch;
    assign o_start_bit = cur.start;
    assign o_underflow_irq = cur.irq;
    assign o_timer_count = cur.tmr;
    assign o_prescaler_count = cur.pre;
    assign o_busy = (cur.st != TOSW_IDLE);

    // stop or a zero start write overrides the state change of an underflow in that cycle, though its irq still fires
    assign abort_now = (cur.st != TOSW_IDLE) &&
                       (i_count_stop || (i_start_wr && !i_start_wdata));

    a_trig_starts: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_IDLE && !i_count_stop && i_start_wr && i_start_wdata)
        |=> (cur.st != TOSW_IDLE && cur.start))
        else $error("start write did not start timer");

    a_trig_loads: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_IDLE && trig)
        |=> (cur.tmr == $past(cur.pri_latch)))
        else $error("trigger did not load primary count");

    a_stop_halts: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_count_stop
        |=> (cur.st == TOSW_IDLE))
        else $error("stop bit did not halt timer");

    a_wait_idle_out: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_WAIT)
        |-> !cur.out_active)
        else $error("output active during wait");

    a_pulse_out: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_PULSE)
        |-> cur.out_active)
        else $error("output idle during pulse");

    a_uf_reload: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_WAIT && tmr_uf && !abort_now)
        |=> (cur.st == TOSW_PULSE && cur.tmr == cur.sec_act))
        else $error("wait underflow did not load secondary");

    a_pulse_ends: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_PULSE && tmr_uf)
        |=> (cur.st == TOSW_IDLE && !cur.out_active))
        else $error("pulse did not end on underflow");

    a_uf_irq: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (tmr_uf && cur.st != TOSW_IDLE)
        |=> o_underflow_irq)
        else $error("underflow without irq");

    a_irq_cause: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_underflow_irq
        |-> $past(tmr_uf))
        else $error("irq without underflow");

    a_pre_reload: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st != TOSW_IDLE && pre_tick)
        |=> (cur.pre == $past(cur.pre_latch)))
        else $error("prescaler did not reload");

    // the extra prescaled count period must not end the interval early
    a_ext_delays: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (pre_tick && cur.tmr == TOSW_ZERO && ext_now && !abort_now &&
         cur.st != TOSW_IDLE && cur.half != TOSW_HALF_HIGH)
        |=> (cur.half == TOSW_HALF_HIGH && cur.st == $past(cur.st)))
        else $error("extension step skipped");

    a_force_end: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st != TOSW_IDLE && i_start_wr && !i_start_wdata)
        |=> (!cur.out_active && !cur.start))
        else $error("forced stop failed");

    a_pin_trig: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_IDLE && !i_count_stop && i_pin_trig_en && pin_edge)
        |=> cur.start)
        else $error("pin trigger did not set start bit");

    a_no_retrig: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_WAIT && !tmr_uf && !abort_now)
        |=> (cur.st == TOSW_WAIT))
        else $error("sequence restarted or skipped");

    a_polarity: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (cur.st == TOSW_IDLE)
        |-> (o_pulse_output_pin == i_level_latch))
        else $error("idle level wrong");

    c_one_shot: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cur.st == TOSW_PULSE && !i_wait_mode ##[1:600] cur.st == TOSW_IDLE);
    c_wait_shot: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cur.st == TOSW_WAIT ##[1:600] cur.st == TOSW_PULSE);
    c_pin_start: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cur.st == TOSW_IDLE && i_pin_trig_en && pin_edge && !i_count_stop);
    c_forced: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cur.st == TOSW_PULSE && i_start_wr && !i_start_wdata);
    c_stop_wait: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        cur.st == TOSW_WAIT && i_count_stop);
endmodule : tosw_timer
`default_nettype wire

// ===== bench/tosw_partner.sv
// far-side model: count source and external trigger pin
`timescale 1ns/1ps
`default_nettype none
module tosw_partner
(
    input wire logic i_ref_clk,
    input wire logic i_set_trig,
    input wire logic i_trig_level,
    output logic o_count_source,
    output logic o_trig_pin
);
    logic [1:0] div = 2'h0;
    // source runs free, one period every four core clocks
    // rising edge, so strobes set at the falling edge are settled
    always_ff @(posedge i_ref_clk)
    begin
        div <= div + 2'h1;
        if (i_set_trig)
        begin
            o_trig_pin <= i_trig_level;
        end
    end
    assign o_count_source = div[1];
endmodule : tosw_partner
`default_nettype wire

// ===== bench/tosw_timer_tb.sv
// self-checking bench for the one-shot pulse timer
`timescale 1ns/1ps
`default_nettype none
module tosw_timer_tb;
    import tosw_pkg::*;
    localparam int SRC_P = 4;
    logic clk = 1'h0, rst_n = 1'h0, wm = 1'h0, stp = 1'h1, lvl = 1'h0;
    logic pen = 1'h0, rise = 1'h0, st_wr = 1'h0, st_d = 1'h0;
    logic pri_wr = 1'h0, sec_wr = 1'h0, pre_wr = 1'h0, ext_wr = 1'h0;
    logic e_p = 1'h0, e_s = 1'h0, set_t = 1'h1, t_lvl = 1'h0;
    logic [7:0] pd = 8'h00, sd = 8'h00, qd = 8'h00, tcnt, qcnt;
    logic src, tpin, pin, sbit, irq, busy, sb;
    int err_count = 0, total_checks = 0, cyc = 0, irq_seen, wt, pw;

    tosw_timer dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_count_source(src),
        .i_wait_mode(wm), .i_count_stop(stp), .i_level_latch(lvl),
        .i_pin_trig_en(pen), .i_trig_rising(rise), .i_trig_pin(tpin),
        .i_start_wr(st_wr), .i_start_wdata(st_d), .i_primary_wr(pri_wr),
        .i_primary_data(pd), .i_secondary_wr(sec_wr),
        .i_secondary_data(sd), .i_prescaler_wr(pre_wr),
        .i_prescaler_data(qd), .i_ext_wr(ext_wr),
        .i_primary_half_cycle_extend(e_p),
        .i_secondary_half_cycle_extend(e_s), .o_pulse_output_pin(pin),
        .o_start_bit(sbit), .o_underflow_irq(irq), .o_timer_count(tcnt),
        .o_prescaler_count(qcnt), .o_busy(busy));
    tosw_partner far (.i_ref_clk(clk), .i_set_trig(set_t),
        .i_trig_level(t_lvl), .o_count_source(src), .o_trig_pin(tpin));

    initial forever #50 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    task automatic check(input bit c, input string m);
        total_checks++;
        if (!c)
        begin
            err_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check

    // one-shot start is free-phase, so width is known to one source period
    function automatic bit in_win(int c, int t, int s);
        return c > (t - 1) * SRC_P && c <= t * SRC_P + s;
    endfunction : in_win

    task automatic load(input logic [7:0] p, s, q, input logic e1, e2);
        {sec_wr, pre_wr, ext_wr} = 3'h7;
        sd = s;
        qd = q;
        e_p = e1;
        e_s = e2;
        @(negedge clk);
        {sec_wr, pre_wr, ext_wr} = 3'h0;
        pri_wr = 1'h1;
        pd = p;
        @(negedge clk);
        pri_wr = 1'h0;
    endtask : load

    task automatic sw_start(input logic v);
        st_wr = 1'h1;
        st_d = v;
        @(negedge clk);
        st_wr = 1'h0;
    endtask : sw_start

    task automatic pin_to(input logic v);
        t_lvl = v;
        set_t = 1'h1;
        @(negedge clk);
        set_t = 1'h0;
    endtask : pin_to

    task automatic measure(input logic poke);
        wt = 0;
        pw = 0;
        irq_seen = 0;
        while (pin === lvl && wt < 2000)
        begin
            @(negedge clk);
            wt++;
            irq_seen += (irq === 1'h1);
        end
        sb = sbit;
        while (pin !== lvl && pw < 2000)
        begin
            st_wr = poke && pw == 6;
            st_d = 1'h1;
            @(negedge clk);
            pw++;
            irq_seen += (irq === 1'h1);
        end
        st_wr = 1'h0;
        repeat (3)
        begin
            @(negedge clk);
            irq_seen += (irq === 1'h1);
        end
    endtask : measure

    task automatic t_reset();
        check(pin === 1'h0 && sbit === 1'h0 && irq === 1'h0, "reset pins");
        check(busy === 1'h0 && tcnt === 8'hff && qcnt === TOSW_ZERO, "rst");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_one_shot();
        load(8'h03, 8'h09, 8'h00, 1'h0, 1'h0);
        stp = 1'h0;
        repeat (20) @(negedge clk);
        check(busy === 1'h0 && pin === 1'h0, "armed yet stopped");
        sw_start(1'h1);
        measure(1'h1);
        check(in_win(pw, 4, 0), "one-shot width");
        check(wt <= 2 && irq_seen == 1, "start and irq");
        check(busy === 1'h0, "stopped at end");
        $display("t_one_shot done");
    endtask : t_one_shot

    task automatic t_extend();
        lvl = 1'h1;
        load(8'h03, 8'h00, 8'h00, 1'h1, 1'h0);
        check(pin === 1'h1, "idle high");
        sw_start(1'h1);
        measure(1'h0);
        check(in_win(pw, 5, 0), "extended low pulse");
        ext_wr = 1'h1;
        e_p = 1'h0;
        @(negedge clk);
        ext_wr = 1'h0;
        sw_start(1'h1);
        measure(1'h0);
        check(in_win(pw, 5, 0), "staged extend unused");
        lvl = 1'h0;
        $display("t_extend done");
    endtask : t_extend

    task automatic t_prescale();
        load(8'h02, 8'h00, 8'h01, 1'h0, 1'h0);
        sw_start(1'h1);
        measure(1'h0);
        check(in_win(pw, 6, 0), "prescaled width");
        $display("t_prescale done");
    endtask : t_prescale

    task automatic t_pin_trig();
        load(8'h03, 8'h00, 8'h00, 1'h0, 1'h0);
        for (int r = 0; r < 2; r++)
        begin
            rise = r[0];
            pen = 1'h0;
            pin_to(r[0]);
            repeat (6) @(negedge clk);
            pen = 1'h1;
            pin_to(!r[0]);
            repeat (8) @(negedge clk);
            check(busy === 1'h0, "wrong edge ignored");
            pin_to(r[0]);
            measure(1'h0);
            check(sb === 1'h1 && in_win(pw, 4, 0),
                "pin start");
        end
        pen = 1'h0;
        $display("t_pin_trig done");
    endtask : t_pin_trig

    task automatic t_abort();
        load(8'h14, 8'h00, 8'h00, 1'h0, 1'h0);
        sw_start(1'h1);
        repeat (10) @(negedge clk);
        sw_start(1'h0);
        repeat (2) @(negedge clk);
        check(pin === 1'h0 && busy === 1'h0 && sbit === 1'h0,
            "forced end");
        wm = 1'h1;
        sw_start(1'h1);
        repeat (10) @(negedge clk);
        stp = 1'h1;
        repeat (2) @(negedge clk);
        check(pin === 1'h0 && busy === 1'h0, "stop halts");
        sw_start(1'h1);
        repeat (4) @(negedge clk);
        check(busy === 1'h0, "start refused while stopped");
        stp = 1'h0;
        $display("t_abort done");
    endtask : t_abort

    task automatic t_wait();
        load(8'h02, 8'h03, 8'h00, 1'h1, 1'h1);
        sw_start(1'h1);
        measure(1'h0);
        check(in_win(wt, 4, 4), "wait length");
        check(in_win(pw, 5, 0) && irq_seen == 2,
            "pulse");
        sec_wr = 1'h1;
        sd = 8'h09;
        @(negedge clk);
        sec_wr = 1'h0;
        sw_start(1'h1);
        measure(1'h0);
        check(in_win(pw, 5, 0), "secondary staged only");
        wm = 1'h0;
        $display("t_wait done");
    endtask : t_wait

    initial
    begin
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        set_t = 1'h0;
        t_reset();
        t_one_shot();
        t_extend();
        t_prescale();
        t_pin_trig();
        t_abort();
        t_wait();
        print_verdict();
    end
endmodule : tosw_timer_tb
`default_nettype wire
